/* rss_defines.vh */
// constants for the rectifier status signaling block
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH
// ****************************************
// timing
// ****************************************
`define RSS_CLK_HZ 20000000
`define RSS_PG_PULSE_US 1000
`define RSS_PG_PULSE_CYC ((`RSS_PG_PULSE_US * (`RSS_CLK_HZ / 1000000)))
`define RSS_BLINK_MS 250
`define RSS_BLINK_CYC ((`RSS_BLINK_MS * (`RSS_CLK_HZ / 1000)))
`define RSS_OTW_MARGIN_C 5
// ****************************************
// mode and field positions
// ****************************************
`define RSS_MODE_ANALOG 2'b01
`define RSS_MODE_RS485 2'b10
`define RSS_ADDR_HI_MSB 3
`define RSS_ADDR_HI_LSB 2
`define RSS_ADDR_LO_MSB 1
`define RSS_ADDR_LO_LSB 0
`endif

/* rss_blink_timer.v */
// free-running toggle generator for blink and pulse rates
`timescale 1ns/1ps
module rss_blink_timer #(
  parameter integer HALF_CYC = 1000,
  parameter integer CW = 24
) (
  input wire ref_clk,      // clock
  input wire resetn,       // async reset, active low
  input wire clk_en,       // clock enable
  output reg wave_q        // square wave, half period HALF_CYC
);
  reg [CW-1:0] cnt_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= {CW{1'b0}};
      wave_q <= 1'b0;
    end else if (clk_en) begin
      if (cnt_q == HALF_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
        cnt_q <= {CW{1'b0}};
        wave_q <= ~wave_q;
      end else begin
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // rss_blink_timer

/* rss_status_signaling.v */
// status, alarm, enable and led logic of the rectifier
// ****************************************
// Summary of operation
// (RULE_01) over-temp warning low once temperature is within margin of shutdown
// (RULE_02) fault alarm high when healthy, low on detected fault
// (RULE_03) power-good warning low when loss of main output is anticipated
// (RULE_04) during overload the power-good warning pulses with 1 ms period
// (RULE_05) analog/two-wire mode: output on when on/off control is grounded
// (RULE_06) open protocol select means analog/two-wire, low resistance means rs485
// (RULE_07) two address levels form address bits a3..a0
// (RULE_08) main output enabled only when slot termination at or below limit
// (RULE_09) hot-plug short pin gates output; ignored on terminal variants
// (RULE_10) input led steady when input ok, blinks when out of limits
// (RULE_11) output led steady when output good, blinks during overload
// (RULE_12) thermal led steady on warning; blinks for service in two-wire mode
// (RULE_13) fault led steady on fault; blinks on lost comms in rs485 mode
// (RULE_14) leds blink at a fixed visible rate set by parameter
// ****************************************
`timescale 1ns/1ps
`include "rss_defines.vh"
module rss_status_signaling #(
  parameter integer BLINK_CYC = `RSS_BLINK_CYC,
  parameter integer PG_PULSE_CYC = `RSS_PG_PULSE_CYC,
  parameter HAS_INTERLOCK = 1'b1,
  parameter integer TEMP_W = 8
) (
  input wire ref_clk,                      // 20 mhz clock
  input wire resetn,                       // async reset, active low
  input wire clk_en,                       // freezes all state when low
  input wire [TEMP_W-1:0] temperature,     // measured temperature, degrees c
  input wire [TEMP_W-1:0] shutdown_temp,   // thermal shutdown point, degrees c
  input wire fault_detect,                 // rectifier fault condition
  input wire output_loss_imminent,         // main output may soon be lost
  input wire overload,                     // unit is in overload
  input wire output_good,                  // main output within regulation
  input wire input_present,                // input power present
  input wire input_in_limits,              // input power within limits
  input wire service_request,              // service requested by controller
  input wire comm_lost,                    // rs485 controller silent
  input wire on_off_n,                     // output control, low = on
  input wire protocol_open,                // protocol select pin left open
  input wire slot_term_ok,                 // slot termination at or below limit
  input wire interlock_mated,              // hot-plug short pin made
  input wire [1:0] first_address_level,    // first address level code
  input wire [1:0] second_address_level,   // second address level code
  input wire overtemp_warning_n_i,         // open-drain wire level, unused
  output reg overtemp_warning_n_o,         // drives low when asserted
  output reg overtemp_warning_n_oe,        // high while pulling low
  output reg fault_alarm_n_o,              // fault alarm level
  output reg fault_alarm_n_oe,             // high while pulling low
  output reg power_good_warn_n_o,          // power-good warning level
  output reg power_good_warn_n_oe,         // high while pulling low
  output reg main_output_en_q,             // enable for main converter
  output reg [1:0] comm_mode_q,            // one-hot communications mode
  output reg [3:0] bus_addr_low_q,         // low nibble of two-wire address
  output reg led_input_q,                  // input led
  output reg led_output_q,                 // output led
  output reg led_thermal_q,                // thermal/service led
  output reg led_fault_q                   // fault led
);
  // ****************************************
  // blink and pulse time bases
  // ****************************************
  wire blink_wave;
  wire pg_wave;

  rss_blink_timer #(.HALF_CYC(BLINK_CYC), .CW(24)) u_blink (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wave_q(blink_wave) // [RULE_14]
  );

  // half period of one pulse cycle; full period is the 1 ms figure
  rss_blink_timer #(.HALF_CYC(PG_PULSE_CYC / 2), .CW(24)) u_pgpulse (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wave_q(pg_wave)
  );

  // ****************************************
  // combinational status
  // ****************************************
  localparam [TEMP_W:0] OTW_MARGIN = `RSS_OTW_MARGIN_C;
  wire [TEMP_W:0] warn_thresh;
  wire otw_hit;
  wire rs485_mode;
  wire out_allowed;
  wire [1:0] mode_d;

  // compare in one extra bit so a temperature near 255 cannot wrap
  assign warn_thresh = {1'b0, temperature} + OTW_MARGIN;
  assign otw_hit = (warn_thresh >= {1'b0, shutdown_temp}); // [RULE_01]
  assign mode_d = protocol_open ? `RSS_MODE_ANALOG : `RSS_MODE_RS485; // [RULE_06]
  assign rs485_mode = comm_mode_q[1];
  // rs485 mode turns on without the control pin; the controller owns it there
  assign out_allowed = (rs485_mode | ~on_off_n) // [RULE_05]
                       & slot_term_ok // [RULE_08]
                       & (~HAS_INTERLOCK | interlock_mated); // [RULE_09]

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      overtemp_warning_n_o <= 1'b0;
      overtemp_warning_n_oe <= 1'b0;
      fault_alarm_n_o <= 1'b0;
      fault_alarm_n_oe <= 1'b0;
      power_good_warn_n_o <= 1'b0;
      power_good_warn_n_oe <= 1'b0;
      main_output_en_q <= 1'b0;
      comm_mode_q <= `RSS_MODE_ANALOG;
      bus_addr_low_q <= 4'h0;
      led_input_q <= 1'b0;
      led_output_q <= 1'b0;
      led_thermal_q <= 1'b0;
      led_fault_q <= 1'b0;
    end else if (clk_en) begin
      overtemp_warning_n_oe <= otw_hit; // [RULE_01]
      fault_alarm_n_oe <= fault_detect; // [RULE_02]
      if (overload) begin
        power_good_warn_n_oe <= pg_wave; // [RULE_04]
      end else begin
        power_good_warn_n_oe <= output_loss_imminent; // [RULE_03]
      end
      // strap is sampled continuously after reset; it is static in practice
      comm_mode_q <= mode_d; // [RULE_06]
      bus_addr_low_q <= {second_address_level, first_address_level}; // [RULE_07]
      main_output_en_q <= out_allowed;
      if (input_in_limits) begin
        led_input_q <= 1'b1; // [RULE_10]
      end else begin
        led_input_q <= input_present & blink_wave; // [RULE_10]
      end
      if (overload) begin
        led_output_q <= blink_wave; // [RULE_11]
      end else begin
        led_output_q <= output_good; // [RULE_11]
      end
      if (otw_hit) begin
        led_thermal_q <= 1'b1; // [RULE_12]
      end else begin
        led_thermal_q <= ~rs485_mode & service_request & blink_wave; // [RULE_12]
      end
      if (fault_detect) begin
        led_fault_q <= 1'b1; // [RULE_13]
      end else begin
        led_fault_q <= rs485_mode & comm_lost & blink_wave; // [RULE_13]
      end
    end
  end
endmodule // rss_status_signaling

/* rss_status_sva.sv */
// concurrent checks on the ports of the rectifier status block
`timescale 1ns/1ps
module rss_status_sva #(parameter HAS_INTERLOCK = 1'b1) (
  input wire ref_clk, resetn, clk_en, fault_detect, output_loss_imminent, // inputs
  input wire overload, output_good, on_off_n, protocol_open, slot_term_ok, // inputs
  input wire interlock_mated, fault_alarm_n_oe, overtemp_warning_n_oe, // pins
  input wire power_good_warn_n_oe, main_output_en_q, led_output_q, led_fault_q, // outputs
  input wire [7:0] temperature, shutdown_temp, // degrees c
  input wire [1:0] first_address_level, second_address_level, comm_mode_q, // codes
  input wire [3:0] bus_addr_low_q // address nibble
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_fault_alarm: assert property (clk_en |=> fault_alarm_n_oe == $past(fault_detect))
    else $error("fault pin not tracking fault");
  // widened by one bit so a temperature near 255 cannot wrap the margin sum
  a_otw_margin: assert property (clk_en |=> overtemp_warning_n_oe ==
    ({1'b0, $past(temperature)} + 9'h005 >= {1'b0, $past(shutdown_temp)}))
    else $error("warning pin wrong for margin");
  a_pg_warn: assert property (clk_en && !overload |=>
    power_good_warn_n_oe == $past(output_loss_imminent)) else $error("pg pin wrong");
  a_main_enable: assert property (clk_en |=> main_output_en_q == (($past(comm_mode_q) ==
    2'h2 || !$past(on_off_n)) && $past(slot_term_ok) && ($past(interlock_mated) ||
    !HAS_INTERLOCK))) else $error("main enable wrong");
  a_mode_select: assert property (clk_en |=> comm_mode_q == ($past(protocol_open) ? 2'h1 : 2'h2))
    else $error("mode wrong");
  a_addr_nibble: assert property (clk_en |=>
    bus_addr_low_q == {$past(second_address_level), $past(first_address_level)})
    else $error("address wrong");
  a_output_led: assert property (clk_en && !overload |=> led_output_q == $past(output_good))
    else $error("output led wrong");
  a_fault_led: assert property (clk_en && fault_detect |-> ##1 led_fault_q)
    else $error("fault led dark on fault");
endmodule // rss_status_sva
bind rss_status_signaling rss_status_sva #(.HAS_INTERLOCK(HAS_INTERLOCK)) u_sva (.*);

/* rss_shelf_model.sv */
// shelf monitor: pull-ups on alarm lines and strapped control pins
`timescale 1ns/1ps
module rss_shelf_model (
  input wire req_on, rs485_strap, fault_alarm_n_oe, overtemp_warning_n_oe, // controls
  input wire power_good_warn_n_oe, // pg sink
  output wire on_off_n, protocol_open, fault_line, otw_line, pg_line // wire levels
);
  assign on_off_n = !req_on;
  assign protocol_open = !rs485_strap;
  // released lines go to the pull-up level, never hold a stale value
  assign fault_line = !fault_alarm_n_oe;
  assign otw_line = !overtemp_warning_n_oe;
  assign pg_line = !power_good_warn_n_oe;
endmodule // rss_shelf_model

/* test_rss_status_signaling.sv */
// self-checking bench for the rectifier status block
`timescale 1ns/1ps
module test_rss_status_signaling;
  reg ref_clk = 1'h0, resetn = 1'h0, fault_detect = 1'h0, output_loss_imminent = 1'h0;
  reg overload = 1'h0, output_good = 1'h1, input_present = 1'h1, input_in_limits = 1'h1;
  reg service_request = 1'h0, comm_lost = 1'h0, slot_term_ok = 1'h1, interlock_mated = 1'h1;
  reg req_on = 1'h1, rs485_strap = 1'h0;
  reg [7:0] temperature = 8'h00, shutdown_temp = 8'h64;
  reg [1:0] first_address_level = 2'h0, second_address_level = 2'h0;
  wire on_off_n, protocol_open, fault_line, otw_line, pg_line, main_output_en_q, led_input_q;
  wire overtemp_warning_n_o, overtemp_warning_n_oe, fault_alarm_n_o, fault_alarm_n_oe;
  wire power_good_warn_n_o, power_good_warn_n_oe, led_output_q, led_thermal_q, led_fault_q;
  wire [1:0] comm_mode_q;
  wire [3:0] bus_addr_low_q;
  wire [4:0] blink_v = {pg_line, led_input_q, led_output_q, led_thermal_q, led_fault_q};
  integer n_fail = 0, n_compared = 0, i;
  // short counts keep every blink and pulse visible within a few dozen cycles
  rss_status_signaling #(.BLINK_CYC(8), .PG_PULSE_CYC(8)) dut (.clk_en(1'h1),
    .overtemp_warning_n_i(otw_line), .*);
  rss_shelf_model model (.*);
  always #25 ref_clk = !ref_clk;
  task step(input integer n); repeat (n) @(posedge ref_clk) #1; endtask
  task chk(input [7:0] seen, input [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h not %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("%0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a whole number of periods in the window makes the toggle count phase-free
  task watch(input [7:0] e_pg, e_in, e_out, e_th, e_fl);
    reg [4:0] p;
    reg [7:0] c [0:4];
    integer k, j;
    for (j = 0; j < 5; j = j + 1) c[j] = 8'h00;
    for (k = 0; k < 64; k = k + 1) begin
      p = blink_v;
      step(1);
      for (j = 0; j < 5; j = j + 1) c[j] = c[j] + {7'h00, p[j] ^ blink_v[j]};
    end
    chk(c[4], e_pg);
    chk(c[3], e_in);
    chk(c[2], e_out);
    chk(c[1], e_th);
    chk(c[0], e_fl);
  endtask
  initial begin
    step(20);
    chk({fault_line, comm_mode_q, main_output_en_q}, 8'h0a);
    resetn = 1'h1;
    step(3);
    chk({fault_line, otw_line, pg_line, led_input_q, led_output_q}, 8'h1f);
    {temperature, fault_detect} = {8'h5e, 1'h1};
    step(2);
    chk({fault_line, otw_line, led_fault_q, led_thermal_q}, 8'h06);
    {temperature, fault_detect, output_loss_imminent} = {8'h5f, 2'h1};
    step(2);
    chk({fault_line, otw_line, pg_line, led_fault_q, led_thermal_q}, 8'h11);
    $display("alarm test done");
    {temperature, overload, input_in_limits, service_request, comm_lost} = {8'h00, 4'hb};
    step(2);
    watch(8'h10, 8'h08, 8'h08, 8'h08, 8'h00);
    rs485_strap = 1'h1;
    step(3);
    watch(8'h10, 8'h08, 8'h08, 8'h00, 8'h08);
    {overload, input_in_limits, service_request, comm_lost, output_loss_imminent} = 5'h08;
    $display("blink test done");
    for (i = 0; i < 16; i = i + 1) begin
      {rs485_strap, req_on, slot_term_ok, interlock_mated} = i[3:0];
      {second_address_level, first_address_level} = i[3:0];
      step(3);
      chk(main_output_en_q, (rs485_strap | req_on) & slot_term_ok & interlock_mated);
      chk(comm_mode_q, rs485_strap ? 2'h2 : 2'h1);
      chk(bus_addr_low_q, i[3:0]);
    end
    $display("strap test done");
    results;
  end
  initial begin
    #200000 n_fail = n_fail + 1;
    results;
  end
endmodule // test_rss_status_signaling
